/* File: design/ess_sequencer.sv */
// EEPROM store sequencer with APB registers and its output FIFO
`timescale 1ns/10ps
`default_nettype none

module ess_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         wr_valid_in,
   output logic             wr_ready_out,
   input  wire logic [W-1:0] wr_data_in,
   output logic             rd_valid_out,
   input  wire logic         rd_ready_in,
   output logic [W-1:0]     rd_data_out
);
   localparam int AW = $clog2(D);
   logic [W-1:0]      mem [D];
   logic [AW-1:0]     wr_ptr_reg;
   logic [AW-1:0]     rd_ptr_reg;
   logic [AW:0]       count_reg;
   wire               do_wr = wr_valid_in && wr_ready_out;
   wire               do_rd = rd_valid_out && rd_ready_in;

   // Full and empty come straight from the count; the count is one bit
   // wider than the pointers, so the full level must not be cut to AW bits
   assign wr_ready_out = (count_reg != (AW + 1)'(D));
   assign rd_valid_out = (count_reg != '0);
   assign rd_data_out  = mem[rd_ptr_reg];

   // Storage needs no reset; only valid words are ever read
   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= wr_data_in;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
      end
   end
endmodule

module ess_sequencer
   import ess_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DEPTH  = FIFO_DEPTH
) (
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   output logic [15:0]            map_addr_out,
   input  wire logic [7:0]        map_rdata_in,
   output logic                   ee_valid_out,
   input  wire logic              ee_ready_in,
   output logic [7:0]             ee_data_out,
   output logic                   ee_last_out,
   output logic [15:0]            ee_addr_out,
   output logic                   busy_out
);
   logic [NUM_ENTRIES-1:0][7:0]  instr_reg;
   logic [NUM_ENTRIES-1:0][15:0] start_reg;
   ess_state_e  state_reg;
   ess_state_e  state_next;
   logic [1:0]  idx_reg;
   logic [7:0]  cnt_reg;
   logic [15:0] map_addr_reg;
   logic [15:0] ptr_reg;
   logic        done_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic [NUM_ENTRIES-1:0] hit_instr;
   logic [NUM_ENTRIES-1:0] hit_start;
   ess_byte_s   push_word;
   ess_byte_s   pop_word;
   logic        push_ready;
   logic        pop_valid;

   // APB decode: one word per register index
   wire [11:0] reg_idx   = paddr_in[13:2];
   wire        access    = psel_in && penable_in;
   wire        apb_wr    = access && pwrite_in;
   wire        setup_rd  = psel_in && !penable_in && !pwrite_in;
   wire        hit_ctrl  = (reg_idx == CTRL_IDX);
   wire        hit_stat  = (reg_idx == STAT_IDX);
   wire        mapped    = (|hit_instr) || (|hit_start) || hit_ctrl
                           || hit_stat;
   wire        ctrl_wr   = apb_wr && hit_ctrl;
   wire        go        = ctrl_wr && pwdata_in[CTRL_GO_BIT] && !busy_out;
   wire        done_clr  = ctrl_wr && pwdata_in[CTRL_CLR_BIT];

   // Zero wait states; read data is caught in the setup cycle
   assign pready_out  = 1'b1;
   assign pslverr_out = access && !mapped;
   assign prdata_out  = prdata_reg;

   // Per-entry list registers, editable by software
   for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_ent
      assign hit_instr[g] = (reg_idx == INSTR_IDX[g]);
      assign hit_start[g] = (reg_idx == START_IDX[g]);
      always_ff @(posedge clk_in) begin
         if (reset_in) begin
            instr_reg[g] <= INSTR_RST[g];
            start_reg[g] <= START_RST[g];
         end else begin
            if (apb_wr && hit_instr[g]) begin
               instr_reg[g] <= pwdata_in[7:0];
            end
            if (apb_wr && hit_start[g]) begin
               start_reg[g] <= pwdata_in[15:0];
            end
         end
      end
   end

   // Read mux; unmapped and write-only words read as zero
   always_comb begin
      rd_mux = 32'h0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         if (hit_instr[i]) begin
            rd_mux = {24'h0, instr_reg[i]};
         end
         if (hit_start[i]) begin
            rd_mux = {16'h0, start_reg[i]};
         end
      end
      if (hit_stat) begin
         rd_mux = {ptr_reg, 14'h0, done_reg, busy_out};
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         prdata_reg <= 32'h0;
      end else if (setup_rd) begin
         prdata_reg <= rd_mux;
      end
   end

   // Byte selection per phase: instruction, high, low, then map data
   wire in_list   = (state_reg == ESS_INSTR) || (state_reg == ESS_HI)
                    || (state_reg == ESS_LO);
   wire push_ok   = (in_list || state_reg == ESS_COPY) && push_ready;
   wire copy_end  = (state_reg == ESS_COPY) && push_ready
                    && (cnt_reg == 8'h0);
   wire last_ent  = (idx_reg == 2'(NUM_ENTRIES - 1));
   assign push_word.data =
      (state_reg == ESS_INSTR) ? instr_reg[idx_reg] :
      (state_reg == ESS_HI)    ? start_reg[idx_reg][15:8] :
      (state_reg == ESS_LO)    ? start_reg[idx_reg][7:0] :
                                 map_rdata_in;
   assign push_word.last = copy_end && last_ent;

   // Sequencer walks the list; back-pressure stalls every byte-pushing phase, ESS_IDLE and ESS_NEXT never wait on it
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ESS_IDLE:  if (go) state_next = ESS_INSTR;
         ESS_INSTR: if (push_ready) state_next = ESS_HI;
         ESS_HI:    if (push_ready) state_next = ESS_LO;
         ESS_LO:    if (push_ready) state_next = ESS_COPY;
         ESS_COPY:  if (copy_end) state_next = ESS_NEXT;
         ESS_NEXT:  state_next = last_ent ? ESS_IDLE : ESS_INSTR;
         default:   state_next = ESS_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= ESS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Entry index rises by one per entry
   always_ff @(posedge clk_in) begin
      if (reset_in || go) begin
         idx_reg <= 2'h0;
      end else if (state_reg == ESS_NEXT) begin
         idx_reg <= idx_reg + 2'h1;
      end
   end

   // Remaining count is N at the instruction byte, zero on the last copy
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cnt_reg <= 8'h0;
      end else if (state_reg == ESS_INSTR && push_ready) begin
         cnt_reg <= instr_reg[idx_reg];
      end else if (state_reg == ESS_COPY && push_ready) begin
         cnt_reg <= cnt_reg - 8'h1;
      end
   end

   // Map address starts at the entry's start word
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         map_addr_reg <= 16'h0;
      end else if (state_reg == ESS_LO && push_ready) begin
         map_addr_reg <= start_reg[idx_reg];
      end else if (state_reg == ESS_COPY && push_ready) begin
         map_addr_reg <= map_addr_reg + 16'h1;
      end
   end
   assign map_addr_out = map_addr_reg;

   ess_fifo #(
      .W ($bits(ess_byte_s)),
      .D (DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .wr_valid_in  (in_list || state_reg == ESS_COPY),
      .wr_ready_out (push_ready),
      .wr_data_in   (push_word),
      .rd_valid_out (pop_valid),
      .rd_ready_in  (ee_ready_in),
      .rd_data_out  (pop_word)
   );

   wire pop = pop_valid && ee_ready_in;
   assign ee_valid_out = pop_valid;
   assign ee_data_out  = pop_word.data;
   assign ee_last_out  = pop_word.last;
   assign ee_addr_out  = ptr_reg;
   // Busy covers bytes still queued, so a new run never races the drain
   assign busy_out = (state_reg != ESS_IDLE) || pop_valid;

   // EEPROM pointer advances once per byte written
   always_ff @(posedge clk_in) begin
      if (reset_in || go) begin
         ptr_reg <= 16'h0;
      end else if (pop) begin
         ptr_reg <= ptr_reg + 16'h1;
      end
   end

   // Done is sticky; a finish in the clearing cycle wins
   wire done_set = (state_reg == ESS_NEXT) && last_ent;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= done_set || (done_reg && !done_clr);
      end
   end

   // Checks next to the logic they guard
   a_instr_byte: assert property (@(posedge clk_in) disable iff (reset_in)
      state_reg == ESS_INSTR && push_ready
      |-> push_word.data == instr_reg[idx_reg] ##1 state_reg == ESS_HI)
      else $error("instruction byte not sent first");
   a_addr_high: assert property (@(posedge clk_in) disable iff (reset_in)
      state_reg == ESS_HI && push_ok
      |-> push_word.data == start_reg[idx_reg][15:8])
      else $error("start address high byte not sent first");
   a_addr_pair: assert property (@(posedge clk_in) disable iff (reset_in)
      state_reg == ESS_INSTR && push_ready
      ##1 (state_reg == ESS_HI && push_ready)
      |-> ##1 state_reg == ESS_LO
      && push_word.data == start_reg[idx_reg][7:0])
      else $error("start address bytes out of order");
   a_map_start: assert property (@(posedge clk_in) disable iff (reset_in)
      state_reg == ESS_COPY
      |-> map_addr_reg == start_reg[idx_reg]
          + {8'h00, 8'(instr_reg[idx_reg] - cnt_reg)})
      else $error("map address not start plus bytes copied");
   a_copy_len: assert property (@(posedge clk_in) disable iff (reset_in)
      copy_end |=> state_reg == ESS_NEXT
      && $past(map_addr_reg) == start_reg[idx_reg]
         + {8'h00, instr_reg[idx_reg]})
      else $error("copy length not count plus one");
   a_ptr_step: assert property (@(posedge clk_in) disable iff (reset_in)
      pop && !go |=> ptr_reg == $past(ptr_reg) + 16'h1)
      else $error("eeprom pointer did not advance");
   a_entry_order: assert property (@(posedge clk_in) disable iff (reset_in)
      state_reg == ESS_NEXT && !last_ent
      |=> state_reg == ESS_INSTR && idx_reg == $past(idx_reg) + 2'h1)
      else $error("entries not taken in ascending order");
   a_loop3_dflt: assert property (@(posedge clk_in)
      reset_in |=> instr_reg[0] == 8'h33 && start_reg[0] == 16'h0740)
      else $error("loop three entry default wrong");
   a_filt_dflt: assert property (@(posedge clk_in)
      reset_in |=> instr_reg[1] == 8'h17 && start_reg[1] == 16'h0800)
      else $error("loop filter entry default wrong");
   a_common_dflt: assert property (@(posedge clk_in)
      reset_in |=> instr_reg[2] == 8'h14 && start_reg[2] == 16'h0a00)
      else $error("common control entry default wrong");
   a_chan0_dflt: assert property (@(posedge clk_in)
      reset_in |=> instr_reg[3] == 8'h04 && start_reg[3] == 16'h0a20)
      else $error("channel 0 entry default wrong");
   a_done_wins: assert property (@(posedge clk_in) disable iff (reset_in)
      done_set |=> done_reg)
      else $error("done lost against clear");

   c_run_done: cover property (@(posedge clk_in) disable iff (reset_in)
      done_set);
   c_stall: cover property (@(posedge clk_in) disable iff (reset_in)
      state_reg == ESS_COPY && !push_ready);
   c_fifo_full_drain: cover property (@(posedge clk_in)
      disable iff (reset_in) !push_ready ##1 pop);
   c_bad_addr: cover property (@(posedge clk_in) disable iff (reset_in)
      pslverr_out);
endmodule

`default_nettype wire

/* File: design/ess_pkg.sv */
// Constants, types and register map of the EEPROM store sequencer
// How it works
// - An instruction byte of value N copies exactly N+1 register-map bytes.
// - Copy start address comes from the two list bytes after the instruction.
// - Instruction byte goes to the EEPROM first; pointer advances by one.
// - Two start-address bytes follow; pointer advances by two.
// - Counted register bytes follow; pointer advances by bytes copied.
// - Loop three divider entry defaults 0x33 at 0x0740, copying 52 bytes.
// - Loop filter entry defaults 0x17 at 0x0800.
// - Common control entry defaults 0x14 at 0x0a00, copying 21 bytes.
// - Channel 0 control entry defaults 0x04 at 0x0a20, copying five bytes.
package ess_pkg;
   // Register indices; the APB byte address is four times the index
   localparam logic [11:0] LOOP3_INSTR_IDX  = 12'he49;
   localparam logic [11:0] LOOP3_START_IDX  = 12'he4a;
   localparam logic [11:0] FILT_INSTR_IDX   = 12'he4c;
   localparam logic [11:0] FILT_START_IDX   = 12'he4d;
   localparam logic [11:0] COMMON_INSTR_IDX = 12'he4f;
   localparam logic [11:0] COMMON_START_IDX = 12'he50;
   localparam logic [11:0] CHAN0_INSTR_IDX  = 12'he52;
   localparam logic [11:0] CHAN0_START_IDX  = 12'he53;
   localparam logic [11:0] CTRL_IDX         = 12'he60;
   localparam logic [11:0] STAT_IDX         = 12'he61;
   // Reset values of the list
   localparam logic [7:0]  LOOP3_INSTR_RST  = 8'h33;
   localparam logic [15:0] LOOP3_START_RST  = 16'h0740;
   localparam logic [7:0]  FILT_INSTR_RST   = 8'h17;
   localparam logic [15:0] FILT_START_RST   = 16'h0800;
   localparam logic [7:0]  COMMON_INSTR_RST = 8'h14;
   localparam logic [15:0] COMMON_START_RST = 16'h0a00;
   localparam logic [7:0]  CHAN0_INSTR_RST  = 8'h04;
   localparam logic [15:0] CHAN0_START_RST  = 16'h0a20;
   // Entry tables, entry 0 in the low slice
   localparam int NUM_ENTRIES = 4;
   localparam logic [3:0][11:0] INSTR_IDX = {CHAN0_INSTR_IDX,
      COMMON_INSTR_IDX, FILT_INSTR_IDX, LOOP3_INSTR_IDX};
   localparam logic [3:0][11:0] START_IDX = {CHAN0_START_IDX,
      COMMON_START_IDX, FILT_START_IDX, LOOP3_START_IDX};
   localparam logic [3:0][7:0] INSTR_RST = {CHAN0_INSTR_RST,
      COMMON_INSTR_RST, FILT_INSTR_RST, LOOP3_INSTR_RST};
   localparam logic [3:0][15:0] START_RST = {CHAN0_START_RST,
      COMMON_START_RST, FILT_START_RST, LOOP3_START_RST};
   // Control and status fields
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_CLR_BIT  = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_PTR_LSB  = 16;
   localparam int FIFO_DEPTH    = 8;
   // Sequencer states, Gray from ESS_IDLE to ESS_NEXT; the steps back from ESS_NEXT are not
   typedef enum logic [2:0] {
      ESS_IDLE  = 3'h0,
      ESS_INSTR = 3'h1,
      ESS_HI    = 3'h3,
      ESS_LO    = 3'h2,
      ESS_COPY  = 3'h6,
      ESS_NEXT  = 3'h7
   } ess_state_e;
   // One byte bound for the EEPROM
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } ess_byte_s;
endpackage

/* File: testbench/ess_eeprom_model.sv */
// Behavioural EEPROM sink that records every stored byte
`timescale 1ns/10ps
`default_nettype none

module ess_eeprom_model (
   input  wire logic        clk_in,
   input  wire logic        hold_in,
   input  wire logic        valid_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        last_in,
   input  wire logic [15:0] addr_in,
   output logic             ready_out
);
   integer      seed = 32'h1446;
   int          n    = 0;
   logic [24:0] mem [0:1023];  // Entry is last, pointer, data

   // Ready has one driver; it settles at the first edge, well inside reset
   // Random stalls keep the FIFO busy; hold forces a long stall
   always @(posedge clk_in) begin
      if (valid_in && ready_out) begin
         mem[n] <= {last_in, addr_in, data_in};
         n      <= n + 1;
      end
      ready_out <= !hold_in && ($random(seed) % 3 != 0);
   end
endmodule

`default_nettype wire

/* File: testbench/tb_eeprom_store_sequencer.sv */
// Self-checking bench for the EEPROM store sequencer
`timescale 1ns/10ps
`default_nettype none

module tb_eeprom_store_sequencer;
   import ess_pkg::*;
   logic        clk_in = 0, reset_in = 1, hold = 0;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 0, map_addr, ee_addr;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err, ee_valid, ee_ready, ee_last, busy;
   logic [7:0]  ee_data, map_rdata;
   int          num_errors = 0, checks_done = 0, cyc = 0, base;
   integer      seed = 32'h1446;
   logic [11:0] ix [4] = '{12'he49, 12'he4c, 12'he4f, 12'he52};
   logic [7:0]  ins [4] = '{8'h33, 8'h17, 8'h14, 8'h04};
   logic [15:0] st [4] = '{16'h0740, 16'h0800, 16'h0a00, 16'h0a20};
   logic [8:0]  exq [$];

   always #25 clk_in = ~clk_in;

   // Register map contents are a simple hash of the address
   function automatic logic [7:0] mb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   assign map_rdata = mb(map_addr);

   ess_sequencer i_dut (
      .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .map_addr_out(map_addr),
      .map_rdata_in(map_rdata), .ee_valid_out(ee_valid),
      .ee_ready_in(ee_ready), .ee_data_out(ee_data),
      .ee_last_out(ee_last), .ee_addr_out(ee_addr), .busy_out(busy));

   ess_eeprom_model i_mod (
      .clk_in(clk_in), .hold_in(hold), .valid_in(ee_valid),
      .data_in(ee_data), .last_in(ee_last), .addr_in(ee_addr),
      .ready_out(ee_ready));

   task final_report;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard: a run takes a few hundred cycles at most
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         final_report;
      end
   end

   task check(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; no wait count assumed, only pready ends it
   task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
      @(posedge clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Build the expected stream from the list, start, then compare
   task run(input logic stall);
      exq = {};
      for (int e = 0; e < 4; e++) begin
         exq.push_back({1'b0, ins[e]});
         exq.push_back({1'b0, st[e][15:8]});
         exq.push_back({1'b0, st[e][7:0]});
         for (int j = 0; j <= ins[e]; j++)
            exq.push_back({1'b0, mb(st[e] + 16'(j))});
      end
      exq[exq.size()-1][8] = 1'b1;
      base = i_mod.n;
      hold <= stall;
      apb(1'b1, 12'he60, 32'h1);
      if (stall) begin
         // Sink refuses everything; FIFO fills and the head waits
         repeat (30) @(posedge clk_in);
         check("valid held", 32'(ee_valid), 32'h1);
         check("ptr held", 32'(ee_addr), 32'h0);
         check("data held", 32'(ee_data), 32'(ins[0]));
         hold <= 1'b0;
      end
      do @(posedge clk_in);
      while (i_mod.n - base < exq.size() || busy !== 1'b0);
      check("byte count", i_mod.n - base, exq.size());
      for (int j = 0; j < exq.size(); j++) begin
         check("byte", 32'(i_mod.mem[base+j][7:0]), 32'(exq[j][7:0]));
         check("ptr", 32'(i_mod.mem[base+j][23:8]), j);
         check("last", 32'(i_mod.mem[base+j][24]), 32'(exq[j][8]));
      end
      apb(1'b0, 12'he61, 32'h0);
      check("status ptr", 32'(rd[31:16]), exq.size());
      check("done", 32'(rd[1:0]), 32'h2);
   endtask

   initial begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      for (int e = 0; e < 4; e++) begin
         apb(1'b0, ix[e], 32'h0);
         check("instr reset", rd, 32'(ins[e]));
         apb(1'b0, ix[e] + 12'h1, 32'h0);
         check("start reset", rd, 32'(st[e]));
      end
      apb(1'b1, 12'h100, 32'h5);
      check("unmapped err", 32'(err), 32'h1);
      apb(1'b0, 12'h100, 32'h0);
      check("unmapped read", rd, 32'h0);
      run(1'b1);
      apb(1'b1, 12'he60, 32'h2);
      apb(1'b0, 12'he61, 32'h0);
      check("done cleared", 32'(rd[1]), 32'h0);
      // Random list, kept short so the run stays brief
      for (int e = 0; e < 4; e++) begin
         ins[e] = 8'($random(seed)) & 8'h0f;
         st[e]  = 16'($random(seed));
         apb(1'b1, ix[e], 32'(ins[e]));
         apb(1'b1, ix[e] + 12'h1, 32'(st[e]));
         apb(1'b0, ix[e] + 12'h1, 32'h0);
         check("start readback", rd, 32'(st[e]));
      end
      run(1'b0);
      final_report;
   end
endmodule

`default_nettype wire
